// [hw/irq_event_ctrl.sv]
// prioritised interrupt controller with event transfer channels
//
// Contract
// - accepted interrupt answered within 8 cycles
// - each request routable to vector or channel
// - channel service steals exactly one cycle
// - moves byte or word, optional pointer increments
// - counter decrements per service unless continuous
// - counter zero raises source vector instead
// - eight independent event transfer channels
// - node control: request, enable, priority
// - sixteen priority levels per node
// - only strictly higher priority preempts service
// - each node has its own vector
// - fast inputs detect rising, falling, both
// - software trap invokes numbered service
// - setting unused request bit raises interrupt
// - end of transfer node: trap 4C, vector 0130
`timescale 1ns/100ps
`include "irq_event_defines.svh"
module irq_event_ctrl (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic [7:0]                paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [`NUM_PERIPH-1:0]    periph_req,
  input  wire logic [`NUM_FAST-1:0]      fast_pin,
  input  wire logic [3:0]                cpu_level,
  input  wire logic                      irq_ack,
  output logic                           irq_req,
  output logic      [8:0]                irq_vec,
  output logic      [3:0]                irq_level,
  output logic      [6:0]                irq_trap,
  output irq_event_pkg::xfer_t           xfer
);
  irq_event_pkg::node_ctrl_t node      [`NUM_NODES];
  irq_event_pkg::node_ctrl_t next_node [`NUM_NODES];
  irq_event_pkg::chan_cfg_t  chan      [`NUM_CHAN];
  irq_event_pkg::chan_cfg_t  next_chan [`NUM_CHAN];
  logic [15:0]               src_ptr      [`NUM_CHAN];
  logic [15:0]               next_src_ptr [`NUM_CHAN];
  logic [15:0]               dst_ptr      [`NUM_CHAN];
  logic [15:0]               next_dst_ptr [`NUM_CHAN];
  logic [`NUM_FAST-1:0]      fast_hit;
  logic [`NUM_NODES-1:0]     hw_set;
  logic [`NUM_NODES-1:0]     clr_node;
  logic                      eot_set;
  irq_event_pkg::ctl_state_t state;
  irq_event_pkg::ctl_state_t next_state;
  irq_event_pkg::xfer_t      next_xfer;
  logic                      next_irq_req;
  logic [8:0]                next_irq_vec;
  logic [3:0]                next_irq_level;
  logic [6:0]                next_irq_trap;
  logic [3:0]                act_idx;
  logic [3:0]                next_act_idx;
  logic                      act_trap;
  logic                      next_act_trap;
  logic [2:0]                act_ch;
  logic [2:0]                next_act_ch;
  logic                      trap_pend;
  logic                      next_trap_pend;
  logic [6:0]                trap_num;
  logic [6:0]                next_trap_num;
  logic                      win_valid;
  logic [3:0]                win_idx;
  logic [3:0]                win_lvl;
  logic [2:0]                win_ch;
  logic                      acc;
  logic                      wr_fire;
  logic                      sel_node;
  logic                      sel_chan;
  logic [3:0]                node_idx;
  logic [2:0]                chan_idx;
  logic [1:0]                chan_reg;
  logic                      addr_ok;
  logic [31:0]               next_prdata;
  logic                      next_pready;
  logic                      next_pslverr;
  function automatic logic [6:0] trap_of(input logic [3:0] idx);
    if (idx == `EOT_NODE) begin
      trap_of = `EOT_TRAP;
    end else begin
      trap_of = `NODE_TRAP_BASE + {3'h0, idx};
    end
  endfunction
  // fast external inputs
  genvar f;
  generate
    for (f = 0; f < `NUM_FAST; f++) begin : g_fast
      fast_edge_detect u_edge (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .pin      (fast_pin[f]),
        .edge_sel (node[f].edge_sel),
        .hit      (fast_hit[f])
      );
    end
  endgenerate

  always_comb begin
    hw_set = {eot_set, periph_req};
    hw_set[`NUM_FAST-1:0] = periph_req[`NUM_FAST-1:0] | fast_hit;
  end

  // apb decode
  always_comb begin
    acc      = psel & penable & ~pready;
    wr_fire  = psel & penable & pready & pwrite;
    node_idx = paddr[5:2];
    sel_node = (paddr[7:6] == 2'h0) && (node_idx < 4'(`NUM_NODES));
    chan_idx = 3'(paddr[7:4] - 4'h4);
    chan_reg = paddr[3:2];
    sel_chan = (paddr >= `CHAN_BASE) && (paddr <= `CHAN_LAST) && (chan_reg != 2'h3);
    addr_ok  = sel_node | sel_chan | (paddr == `TRAP_ADDR) | (paddr == `STATUS_ADDR);
    next_pready  = acc;
    next_pslverr = acc & ~addr_ok;
    next_prdata  = prdata;
    if (acc) begin
      next_prdata = 32'h0000_0000;
      if (sel_node) begin
        next_prdata = {20'h0_0000, node[node_idx]};
      end else if (sel_chan) begin
        unique case (chan_reg)
          `CHAN_CTRL_REG: next_prdata = {20'h0_0000, chan[chan_idx]};
          `CHAN_SRC_REG:  next_prdata = {16'h0000, src_ptr[chan_idx]};
          `CHAN_DST_REG:  next_prdata = {16'h0000, dst_ptr[chan_idx]};
          default:        next_prdata = 32'h0000_0000;
        endcase
      end else if (paddr == `STATUS_ADDR) begin
        next_prdata = {20'h0_0000, act_idx, trap_pend, irq_req, xfer.valid, win_valid, win_lvl};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // node control registers, hardware set wins over clear
  genvar n;
  generate
    for (n = 0; n < `NUM_NODES; n++) begin : g_node
      always_comb begin
        next_node[n] = node[n];
        if (wr_fire && sel_node && node_idx == 4'(n)) begin
          next_node[n] = pwdata[`CTRL_W-1:0];
        end
        if (clr_node[n]) begin
          next_node[n].req = 1'b0;
        end
        if (hw_set[n]) begin
          next_node[n].req = 1'b1;
        end
      end
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          node[n] <= `NODE_CTRL_RST;
        end else begin
          node[n] <= next_node[n];
        end
      end
    end
  endgenerate

  // event transfer channels
  genvar c;
  generate
    for (c = 0; c < `NUM_CHAN; c++) begin : g_chan
      always_comb begin
        next_chan[c]    = chan[c];
        next_src_ptr[c] = src_ptr[c];
        next_dst_ptr[c] = dst_ptr[c];
        if (wr_fire && sel_chan && chan_idx == 3'(c)) begin
          unique case (chan_reg)
            `CHAN_CTRL_REG: next_chan[c] = pwdata[`CTRL_W-1:0];
            `CHAN_SRC_REG:  next_src_ptr[c] = pwdata[15:0];
            `CHAN_DST_REG:  next_dst_ptr[c] = pwdata[15:0];
            default:        next_chan[c] = chan[c];
          endcase
        end
        if (state == irq_event_pkg::S_MOVE && act_ch == 3'(c)) begin
          if (!chan[c].cont) begin
            next_chan[c].count = chan[c].count - 8'h01;
          end
          if (chan[c].src_inc) begin
            next_src_ptr[c] = src_ptr[c] +
              (chan[c].byte_mode ? `PTR_BYTE_STEP : `PTR_WORD_STEP);
          end
          if (chan[c].dst_inc) begin
            next_dst_ptr[c] = dst_ptr[c] +
              (chan[c].byte_mode ? `PTR_BYTE_STEP : `PTR_WORD_STEP);
          end
        end
      end
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          chan[c]    <= `CHAN_CTRL_RST;
          src_ptr[c] <= `PTR_RST;
          dst_ptr[c] <= `PTR_RST;
        end else begin
          chan[c]    <= next_chan[c];
          src_ptr[c] <= next_src_ptr[c];
          dst_ptr[c] <= next_dst_ptr[c];
        end
      end
    end
  endgenerate

  // arbitration: above cpu level, highest level, lowest index on ties
  always_comb begin
    win_valid = 1'b0;
    win_idx   = 4'h0;
    win_lvl   = 4'h0;
    for (int k = 0; k < `NUM_NODES; k++) begin
      if (node[k].en && node[k].req && node[k].level > cpu_level &&
          (!win_valid || node[k].level > win_lvl)) begin
        win_valid = 1'b1;
        win_idx   = 4'(k);
        win_lvl   = node[k].level;
      end
    end
    win_ch = node[win_idx].chan;
  end

  // service control
  always_comb begin
    next_state     = state;
    next_xfer      = xfer;
    next_xfer.valid = 1'b0;
    next_irq_req   = irq_req;
    next_irq_vec   = irq_vec;
    next_irq_level = irq_level;
    next_irq_trap  = irq_trap;
    next_act_idx   = act_idx;
    next_act_trap  = act_trap;
    next_act_ch    = act_ch;
    next_trap_pend = trap_pend;
    next_trap_num  = trap_num;
    clr_node       = '0;
    eot_set        = 1'b0;
    unique case (state)
      irq_event_pkg::S_IDLE: begin
        if (trap_pend) begin
          next_trap_pend = 1'b0;
          next_act_trap  = 1'b1;
          next_irq_req   = 1'b1;
          next_irq_trap  = trap_num;
          next_irq_vec   = {trap_num, 2'b00};
          next_irq_level = cpu_level;
          next_state     = irq_event_pkg::S_PRESENT;
        end else if (win_valid) begin
          next_act_idx  = win_idx;
          next_act_trap = 1'b0;
          next_act_ch   = win_ch;
          if (node[win_idx].route && (chan[win_ch].cont || chan[win_ch].count != 8'h00)) begin
            next_xfer.valid     = 1'b1;
            next_xfer.byte_mode = chan[win_ch].byte_mode;
            next_xfer.src       = src_ptr[win_ch];
            next_xfer.dst       = dst_ptr[win_ch];
            next_state          = irq_event_pkg::S_MOVE;
          end else begin
            next_irq_req   = 1'b1;
            next_irq_trap  = trap_of(win_idx);
            next_irq_vec   = {trap_of(win_idx), 2'b00};
            next_irq_level = win_lvl;
            next_state     = irq_event_pkg::S_PRESENT;
          end
        end
      end
      irq_event_pkg::S_MOVE: begin
        clr_node[act_idx] = 1'b1;
        eot_set = !chan[act_ch].cont && chan[act_ch].count == 8'h01;
        next_state = irq_event_pkg::S_IDLE;
      end
      irq_event_pkg::S_PRESENT: begin
        if (irq_ack) begin
          next_irq_req = 1'b0;
          clr_node[act_idx] = ~act_trap;
          next_state = irq_event_pkg::S_IDLE;
        end else if (!act_trap && win_valid && win_lvl > irq_level &&
                     (!node[win_idx].route ||
                      (!chan[win_ch].cont && chan[win_ch].count == 8'h00))) begin
          next_act_idx   = win_idx;
          next_act_ch    = win_ch;
          next_irq_trap  = trap_of(win_idx);
          next_irq_vec   = {trap_of(win_idx), 2'b00};
          next_irq_level = win_lvl;
        end
      end
    endcase
    if (wr_fire && paddr == `TRAP_ADDR) begin
      next_trap_pend = 1'b1;
      next_trap_num  = pwdata[6:0];
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state     <= irq_event_pkg::S_IDLE;
      xfer      <= '0;
      irq_req   <= 1'b0;
      irq_vec   <= 9'h000;
      irq_level <= 4'h0;
      irq_trap  <= 7'h00;
      act_idx   <= 4'h0;
      act_trap  <= 1'b0;
      act_ch    <= 3'h0;
      trap_pend <= 1'b0;
      trap_num  <= 7'h00;
    end else begin
      state     <= next_state;
      xfer      <= next_xfer;
      irq_req   <= next_irq_req;
      irq_vec   <= next_irq_vec;
      irq_level <= next_irq_level;
      irq_trap  <= next_irq_trap;
      act_idx   <= next_act_idx;
      act_trap  <= next_act_trap;
      act_ch    <= next_act_ch;
      trap_pend <= next_trap_pend;
      trap_num  <= next_trap_num;
    end
  end
endmodule

// [inc/irq_event_defines.svh]
// constants for the interrupt and event transfer block
`ifndef IRQ_EVENT_DEFINES_SVH
`define IRQ_EVENT_DEFINES_SVH
`define NUM_NODES      9
`define NUM_CHAN       8
`define NUM_FAST       2
`define NUM_PERIPH     8
`define EOT_NODE       4'h8
`define EOT_TRAP       7'h4C
`define NODE_TRAP_BASE 7'h40
`define RESP_CYCLES    8
`define NODE_CTRL_RST  12'h000
`define CHAN_CTRL_RST  12'h000
`define PTR_RST        16'h0000
`define PTR_WORD_STEP  16'h0002
`define PTR_BYTE_STEP  16'h0001
`define NODE_BASE      8'h00
`define CHAN_BASE      8'h40
`define CHAN_LAST      8'hBF
`define CHAN_CTRL_REG  2'h0
`define CHAN_SRC_REG   2'h1
`define CHAN_DST_REG   2'h2
`define TRAP_ADDR      8'hC0
`define STATUS_ADDR    8'hC4
`define CTRL_W         12
`define LVL_MSB        3
`define LVL_LSB        0
`define EN_BIT         4
`define REQ_BIT        5
`define ROUTE_BIT      6
`define CHSEL_MSB      9
`define CHSEL_LSB      7
`define EDGE_MSB       11
`define EDGE_LSB       10
`define CNT_MSB        7
`define CNT_LSB        0
`define BYTE_BIT       8
`define SRC_INC_BIT    9
`define DST_INC_BIT    10
`define CONT_BIT       11
`endif

// [inc/irq_event_pkg.sv]
// types for the interrupt and event transfer block
package irq_event_pkg;
  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_t;
  typedef struct packed {
    edge_sel_t  edge_sel;
    logic [2:0] chan;
    logic       route;
    logic       req;
    logic       en;
    logic [3:0] level;
  } node_ctrl_t;
  typedef struct packed {
    logic       cont;
    logic       dst_inc;
    logic       src_inc;
    logic       byte_mode;
    logic [7:0] count;
  } chan_cfg_t;
  typedef struct packed {
    logic        valid;
    logic        byte_mode;
    logic [15:0] src;
    logic [15:0] dst;
  } xfer_t;
  typedef enum {S_IDLE, S_MOVE, S_PRESENT} ctl_state_t;
endpackage

// [hw/fast_edge_detect.sv]
// synchronised edge detector for one fast external interrupt pin
`timescale 1ns/100ps
`include "irq_event_defines.svh"
module fast_edge_detect (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic                   pin,
  input  wire irq_event_pkg::edge_sel_t edge_sel,
  output logic                        hit
);
  logic sync1;
  logic sync2;
  logic sync3;
  logic stable;
  logic next_stable;
  logic next_hit;
  logic rise;
  logic fall;

  always_comb begin
    next_stable = (sync2 == sync3) ? sync3 : stable;
    rise        = next_stable & ~stable;
    fall        = ~next_stable & stable;
    next_hit    = 1'b0;
    unique case (edge_sel)
      irq_event_pkg::EDGE_OFF:  next_hit = 1'b0;
      irq_event_pkg::EDGE_RISE: next_hit = rise;
      irq_event_pkg::EDGE_FALL: next_hit = fall;
      irq_event_pkg::EDGE_BOTH: next_hit = rise | fall;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1  <= 1'b0;
      sync2  <= 1'b0;
      sync3  <= 1'b0;
      stable <= 1'b0;
      hit    <= 1'b0;
    end else begin
      sync1  <= pin;
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= next_stable;
      hit    <= next_hit;
    end
  end
endmodule

// [bench/irq_event_ctrl_properties.sv]
// port assertions for the interrupt and event transfer controller
`timescale 1ns/100ps
module irq_event_checker (
  input wire logic                 clk_sys,
  input wire logic                 arst_n,
  input wire logic [7:0]           paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic [3:0]           cpu_level,
  input wire logic                 irq_ack,
  input wire logic                 irq_req,
  input wire logic [8:0]           irq_vec,
  input wire logic [3:0]           irq_level,
  input wire logic [6:0]           irq_trap,
  input wire irq_event_pkg::xfer_t xfer
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic       wr_done;
  logic [6:0] trap_num;
  logic [6:0] next_trap_num;
  assign wr_done = psel && penable && pready && pwrite;
  // last software trap number written
  always_comb begin
    next_trap_num = trap_num;
    if (wr_done && paddr == 8'hC0) begin
      next_trap_num = pwdata[6:0];
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trap_num <= 7'h00;
    end else begin
      trap_num <= next_trap_num;
    end
  end
  property p_apb_pulse;
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready held too long");
  property p_xfer_pulse;
    xfer.valid |=> !xfer.valid;
  endproperty
  a_xfer_pulse: assert property (p_xfer_pulse)
    else $error("transfer took more than one cycle");
  property p_xfer_alone;
    xfer.valid |-> !irq_req;
  endproperty
  a_xfer_alone: assert property (p_xfer_alone)
    else $error("transfer raised a vector");
  property p_vec;
    irq_req |-> irq_vec == {irq_trap, 2'b00};
  endproperty
  a_vec: assert property (p_vec) else $error("vector not trap times four");
  property p_eot;
    irq_req && irq_trap == 7'h4C |-> irq_vec == 9'h130;
  endproperty
  a_eot: assert property (p_eot) else $error("end node vector wrong");
  property p_above;
    irq_req && irq_trap[6:4] == 3'h4 |-> irq_level > cpu_level;
  endproperty
  a_above: assert property (p_above) else $error("level not above cpu");
  property p_hold;
    irq_req && !irq_ack |=> irq_req && irq_level >= $past(irq_level);
  endproperty
  a_hold: assert property (p_hold) else $error("presented level fell");
  property p_ack;
    irq_ack |=> !irq_req;
  endproperty
  a_ack: assert property (p_ack) else $error("request kept after ack");
  property p_trap;
    wr_done && paddr == 8'hC0 |-> ##[1:8] (irq_req && irq_trap == trap_num);
  endproperty
  a_trap: assert property (p_trap) else $error("software trap not taken");
  property p_resp;
    wr_done && paddr <= 8'h20 && pwdata[6:4] == 3'b011 && pwdata[3:0] > cpu_level
      |-> ##[1:8] irq_req;
  endproperty
  a_resp: assert property (p_resp) else $error("no answer in eight cycles");
  c_xfer: cover property (xfer.valid);
  c_eot: cover property (irq_ack && irq_trap == 7'h4C);
  c_high: cover property (irq_ack && irq_level == 4'h9);
endmodule
bind irq_event_ctrl irq_event_checker chk_i (.clk_sys, .arst_n, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pready, .cpu_level, .irq_ack, .irq_req, .irq_vec, .irq_level,
  .irq_trap, .xfer);

// [bench/cpu_model.sv]
// cpu core model: acks presented interrupts and holds its level
`timescale 1ns/100ps
module cpu_model #(
  parameter int SVC = 12
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       slow,
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_level,
  input  wire logic [6:0] irq_trap,
  output logic            irq_ack,
  output logic [3:0]      cpu_level,
  output logic            busy
);
  logic [6:0] log_q [$];
  int         cnt;
  // one service at a time, level restored when it ends
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_ack <= 1'b0;
      cpu_level <= 4'h0;
      busy <= 1'b0;
      cnt <= 0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      log_q.push_back(irq_trap);
      cpu_level <= irq_level;
      busy <= 1'b1;
      cnt <= SVC;
    end else if (busy) begin
      if (cnt == 0) begin
        busy <= 1'b0;
        cpu_level <= 4'h0;
      end else begin
        cnt <= cnt - 1;
      end
    end else if (irq_req) begin
      if (cnt >= (slow ? 5 : 0)) begin
        irq_ack <= 1'b1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// [bench/irq_event_ctrl_tb.sv]
// testbench for the interrupt and event transfer controller
`timescale 1ns/100ps
module irq_event_ctrl_tb;
  logic                 clk_sys = 1'b0;
  logic                 arst_n = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [7:0]           periph_req = 8'h00;
  logic [1:0]           fast_pin = 2'h0;
  logic                 slow = 1'b0;
  logic [3:0]           cpu_level;
  logic                 irq_ack;
  logic                 irq_req;
  logic                 busy;
  logic [8:0]           irq_vec;
  logic [3:0]           irq_level;
  logic [6:0]           irq_trap;
  irq_event_pkg::xfer_t xfer;
  irq_event_pkg::xfer_t xq [$];
  int                   n_fail = 0;
  int                   n_checks = 0;
  int                   cycles = 0;
  always #12.5 clk_sys = ~clk_sys;
  irq_event_ctrl dut (.clk_sys, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .periph_req, .fast_pin, .cpu_level, .irq_ack, .irq_req,
    .irq_vec, .irq_level, .irq_trap, .xfer);
  cpu_model cpu (.clk_sys, .arst_n, .slow, .irq_req, .irq_level, .irq_trap, .irq_ack,
    .cpu_level, .busy);
  task report_and_stop;
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (xfer.valid === 1'b1) xq.push_back(xfer);
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task pulse(input logic [7:0] m);
    periph_req <= m;
    @(posedge clk_sys);
    periph_req <= 8'h00;
    repeat (2) @(posedge clk_sys);
  endtask
  task want_trap(input logic [6:0] t);
    int k;
    k = 0;
    while (cpu.log_q.size() == 0 && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    chk(cpu.log_q.size() > 0 ? cpu.log_q.pop_front() : 7'h7F, t);
  endtask
  task want_xfer(input logic [32:0] e);
    int k;
    irq_event_pkg::xfer_t x;
    k = 0;
    while (xq.size() == 0 && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    x = xq.size() > 0 ? xq.pop_front() : '0;
    chk({x.byte_mode, x.src, x.dst}, e);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(8'h08, 33'h0);
    rd(8'h4C, 33'h1_0000_0000);
    wr(8'hC0, 32'h05);
    want_trap(7'h05);
    wr(8'h20, 32'h032);
    want_trap(7'h4C);
    slow <= 1'b1;
    wr(8'h08, 32'h015);
    rd(8'h08, 33'h015);
    wr(8'h14, 32'h019);
    wr(8'h18, 32'h019);
    pulse(8'h04);
    pulse(8'h60);
    want_trap(7'h45);
    repeat (6) begin
      @(posedge clk_sys);
      chk(irq_req, 1'b0);
    end
    chk({busy, cpu_level}, 36'h19);
    rd(8'hC4, 33'h0_0000_0500);
    want_trap(7'h46);
    want_trap(7'h42);
    slow <= 1'b0;
    wr(8'h50, 32'h602);
    wr(8'h54, 32'h1000);
    wr(8'h58, 32'h2000);
    wr(8'h20, 32'h012);
    wr(8'h0C, 32'h0D3);
    pulse(8'h08);
    want_xfer({1'b0, 16'h1000, 16'h2000});
    pulse(8'h08);
    want_xfer({1'b0, 16'h1002, 16'h2002});
    want_trap(7'h4C);
    pulse(8'h08);
    want_trap(7'h43);
    rd(8'h50, 33'h600);
    wr(8'hB0, 32'hB00);
    wr(8'hB4, 32'h0010);
    wr(8'hB8, 32'h0030);
    wr(8'h10, 32'h3D4);
    pulse(8'h10);
    want_xfer({1'b1, 16'h0010, 16'h0030});
    pulse(8'h10);
    want_xfer({1'b1, 16'h0011, 16'h0030});
    rd(8'hB0, 33'hB00);
    wr(8'h00, 32'h411);
    wr(8'h04, 32'hC11);
    fast_pin <= 2'b11;
    want_trap(7'h40);
    want_trap(7'h41);
    fast_pin <= 2'b00;
    want_trap(7'h41);
    wr(8'h00, 32'h811);
    fast_pin <= 2'b01;
    repeat (20) @(posedge clk_sys);
    fast_pin <= 2'b00;
    want_trap(7'h40);
    repeat (40) @(posedge clk_sys);
    chk(cpu.log_q.size(), 36'h0);
    chk(xq.size(), 36'h0);
    report_and_stop();
  end
endmodule
